// [src/pwm_cycle_pkg.sv]
package pwm_cycle_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CFG_ADDR = 8'hda;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int BIT_RELOAD_SEL = 7;
    localparam int BIT_IRQ_MASK = 6;
    localparam int BIT_WRAP_FLAG = 5;
    localparam int CLSEL_LSB = 0;
    localparam int CLSEL_MSB = 1;
    // Writable bits; 4:2 always read zero
    localparam logic [7:0] CFG_WMASK = 8'he3;
    // Channel compare address base, high/low alternate
    localparam int NUM_CH = 6;
    localparam logic [7:0] CMP_LOW_BASE = 8'he9;
    localparam logic [7:0] CMP_HIGH_BASE = 8'hea;
    localparam logic [7:0] CMP_STRIDE = 8'h02;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [10:0] CNT_RESET = 11'h000;

    typedef enum logic [1:0] {
        LEN_8 = 2'h0,
        LEN_9 = 2'h1,
        LEN_10 = 2'h2,
        LEN_11 = 2'h3
    } cycle_len_t;
endpackage : pwm_cycle_pkg

// [src/pwm_cycle_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_cycle_channel
    import pwm_cycle_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_bank_sel,
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic [7:0] i_wdata,
    input wire logic i_wrap,
    input wire logic i_wide,
    input wire logic i_pwm_en,
    input wire logic [1:0] i_len,
    input wire logic [10:0] i_count,
    output logic [15:0] o_cmp,
    output logic [15:0] o_reload,
    output logic o_pwm
);
    logic [15:0] cmp_q;
    logic [15:0] reload_q;
    logic [15:0] cmp_d;
    logic [15:0] reload_d;
    logic reload_mode;
    logic [10:0] mask;

    // Reload only meaningful in 9..11-bit narrow mode
    assign reload_mode = i_pwm_en && !i_wide && (i_len != LEN_8);
    // Counter bits that take part in a narrow cycle
    assign mask = {(i_len == LEN_11), (i_len >= LEN_10), (i_len >= LEN_9),
        8'hff};

    // Bus writes go to one bank; wrap transfer loads compare
    always_comb begin
        cmp_d = cmp_q;
        reload_d = reload_q;
        if (i_wrap && reload_mode)
            cmp_d = reload_q;
        if (!i_bank_sel && i_wr_low)
            cmp_d[7:0] = i_wdata;
        if (!i_bank_sel && i_wr_high)
            cmp_d[15:8] = i_wdata;
        if (i_bank_sel && i_wr_low)
            reload_d[7:0] = i_wdata;
        if (i_bank_sel && i_wr_high)
            reload_d[15:8] = i_wdata;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmp_q <= CMP_RESET;
            reload_q <= CMP_RESET;
            o_pwm <= 1'b0;
        end else begin
            cmp_q <= cmp_d;
            reload_q <= reload_d;
            if (!i_pwm_en)
                o_pwm <= 1'b0;
            else if (i_wide)
                o_pwm <= {5'h00, i_count} < cmp_q;
            else
                o_pwm <= (i_count & mask[10:0]) < (cmp_q[10:0] & mask[10:0]);
        end
    end
    assign o_cmp = cmp_q;
    assign o_reload = reload_q;
endmodule : pwm_cycle_channel
`default_nettype wire

// [src/pwm_cycle_config.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Select bit 0 maps normal compare
// - Select bit 1 maps auto-reload registers
// - Reload used only in 9-11 bit modes
// - Mask bit 6 gates wrap interrupt
// - Counter overflow at chosen bit sets flag
// - Software sets flag; only software clears
// - Length field picks 8/9/10/11 bits
// - Length applies except wide channels
// - Bits 4:2 read zero, ignore writes
// - Per-channel wide bit chooses 16-bit
module pwm_cycle_config
    import pwm_cycle_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_cnt_tick,
    input wire logic [NUM_CH-1:0] i_pwm_en,
    input wire logic [NUM_CH-1:0] i_wide_pwm_select,
    output logic [7:0] o_sfr_rdata,
    output logic o_irq,
    output logic o_cycle_wrap_flag,
    output logic [NUM_CH-1:0] o_pwm
);
    // ****************************************
    // Reset synchroniser
    // ****************************************
    // Reset asserts at once but leaves on a clock edge; the first
    // flop may go metastable, so only the second one feeds the logic
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************
    // Configuration register
    // ****************************************
    // Fields of the configuration byte and the shared counter
    logic reload_bank_select_q;
    logic cycle_wrap_irq_mask_q;
    logic cycle_wrap_flag_q;
    logic cycle_wrap_flag_d;
    logic [1:0] cycle_length_select_q;
    logic cfg_sel;
    logic cfg_wr;
    logic irq_mask_d;
    logic wrap;
    logic [10:0] array_main_counter_q;
    logic [10:0] cnt_inc;

    // Byte addresses of one channel's compare pair
    function automatic logic [7:0] low_addr(input int ch);
        low_addr = CMP_LOW_BASE + 8'(ch) * CMP_STRIDE;
    endfunction : low_addr

    function automatic logic [7:0] high_addr(input int ch);
        high_addr = CMP_HIGH_BASE + 8'(ch) * CMP_STRIDE;
    endfunction : high_addr

    // Address decode for the configuration register
    assign cfg_sel = i_sfr_addr == CFG_ADDR;
    assign cfg_wr = i_sfr_wr && cfg_sel;
    // Mask as it will stand after this edge
    assign irq_mask_d = cfg_wr ? i_sfr_wdata[BIT_IRQ_MASK]
        : cycle_wrap_irq_mask_q;
    // Plain 11-bit increment; the top carry is dropped on purpose
    assign cnt_inc = array_main_counter_q + 11'h001;

    // Overflow is seen before the increment, so the flag rises on
    // the same edge that carries the counter out of the chosen bit
    // length decode
    always_comb begin
        wrap = 1'b0;
        if (i_cnt_tick) begin
            unique case (cycle_wrap_len())
                LEN_8: wrap = array_main_counter_q[7:0] == 8'hff;
                LEN_9: wrap = array_main_counter_q[8:0] == 9'h1ff;
                LEN_10: wrap = array_main_counter_q[9:0] == 10'h3ff;
                LEN_11: wrap = array_main_counter_q[10:0] == 11'h7ff;
            endcase
        end
    end

    // Length code seen as the enum the decode expects
    function automatic cycle_len_t cycle_wrap_len();
        cycle_wrap_len = cycle_len_t'(cycle_length_select_q);
    endfunction : cycle_wrap_len

    // A clear that meets an overflow loses, so no wrap goes unseen
    // set wins over clear; hardware never clears
    always_comb begin
        cycle_wrap_flag_d = cycle_wrap_flag_q;
        if (cfg_wr)
            cycle_wrap_flag_d = i_sfr_wdata[BIT_WRAP_FLAG];
        if (wrap)
            cycle_wrap_flag_d = 1'b1;
    end

    // Software-owned fields; bits 4:2 have no storage at all
    // unused bits not stored
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reload_bank_select_q <= CFG_RESET[BIT_RELOAD_SEL];
            cycle_wrap_irq_mask_q <= CFG_RESET[BIT_IRQ_MASK];
            cycle_length_select_q <= CFG_RESET[CLSEL_MSB:CLSEL_LSB];
        end else if (cfg_wr) begin
            reload_bank_select_q <= i_sfr_wdata[BIT_RELOAD_SEL];
            cycle_wrap_irq_mask_q <= i_sfr_wdata[BIT_IRQ_MASK];
            cycle_length_select_q <= i_sfr_wdata[CLSEL_MSB:CLSEL_LSB];
        end
    end

    // Flag register; its next value is resolved above
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q)
            cycle_wrap_flag_q <= CFG_RESET[BIT_WRAP_FLAG];
        else
            cycle_wrap_flag_q <= cycle_wrap_flag_d;
    end

    // Counter of advance pulses; wraps silently at 11 bits
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q)
            array_main_counter_q <= CNT_RESET;
        else if (i_cnt_tick)
            array_main_counter_q <= cnt_inc;
    end

    // Request follows the next mask and flag, so a masking write
    // silences it on the same edge rather than one cycle late
    // mask gates flag
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q)
            o_irq <= 1'b0;
        else
            o_irq <= irq_mask_d && cycle_wrap_flag_d;
    end

    // Flag is visible as its own pin for the interrupt logic
    assign o_cycle_wrap_flag = cycle_wrap_flag_q;

    // ****************************************
    // Channels and read mux
    // ****************************************
    // The length field reaches the channels directly, so changing it
    // mid-cycle can end that cycle early or late; change it with outputs off
    logic [15:0] ch_cmp [NUM_CH];
    logic [15:0] ch_rel [NUM_CH];
    logic [15:0] ch_view [NUM_CH];
    logic [NUM_CH-1:0] wr_low;
    logic [NUM_CH-1:0] wr_high;
    logic [7:0] rd_mux;
    logic [7:0] cfg_rd;

    assign cfg_rd = {reload_bank_select_q, cycle_wrap_irq_mask_q,
        cycle_wrap_flag_q, 3'h0, cycle_length_select_q} & CFG_WMASK;

    // Both banks share one address pair; the select bit steers
    // writes inside the channel and reads through ch_view
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        // One decoded strobe per compare byte
        assign wr_low[g] = i_sfr_wr && (i_sfr_addr == low_addr(g));
        assign wr_high[g] = i_sfr_wr && (i_sfr_addr == high_addr(g));
        assign ch_view[g] = reload_bank_select_q ? ch_rel[g] : ch_cmp[g];
        pwm_cycle_channel pwm_cycle_channel_i (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(rst_n_q),
            .i_bank_sel(reload_bank_select_q),
            .i_wr_low(wr_low[g]),
            .i_wr_high(wr_high[g]),
            .i_wdata(i_sfr_wdata),
            .i_wrap(wrap),
            .i_wide(i_wide_pwm_select[g]),
            .i_pwm_en(i_pwm_en[g]),
            .i_len(cycle_length_select_q),
            .i_count(array_main_counter_q),
            .o_cmp(ch_cmp[g]),
            .o_reload(ch_rel[g]),
            .o_pwm(o_pwm[g])
        );
    end

    // Addresses never overlap, so the order of the tests is free
    always_comb begin
        rd_mux = 8'h00;
        if (cfg_sel)
            rd_mux = cfg_rd;
        for (int c = 0; c < NUM_CH; c++) begin
            if (i_sfr_addr == low_addr(c))
                rd_mux = ch_view[c][7:0];
            if (i_sfr_addr == high_addr(c))
                rd_mux = ch_view[c][15:8];
        end
    end

    // Registered read data, valid one cycle after strobe
    // Held between reads so a slow reader still sees a steady byte
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
            o_sfr_rdata <= rd_mux;
    end
endmodule : pwm_cycle_config
`default_nettype wire

// [verification/pwm_cycle_config_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_cycle_config_props
    import pwm_cycle_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_cnt_tick,
    input wire logic [NUM_CH-1:0] i_pwm_en,
    input wire logic [NUM_CH-1:0] i_wide_pwm_select,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_irq,
    input wire logic o_cycle_wrap_flag,
    input wire logic [NUM_CH-1:0] o_pwm
);
    // ****************************************
    // Config register properties
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // Decoded config accesses, kept as wires so $past sees one signal
    wire logic cw = i_sfr_wr && i_sfr_addr == CFG_ADDR;
    wire logic cr = i_sfr_rd && i_sfr_addr == CFG_ADDR;
    wire logic clr = cw && !i_sfr_wdata[BIT_WRAP_FLAG];
    property p_irq; o_irq |-> o_cycle_wrap_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_msk; cw && !i_sfr_wdata[BIT_IRQ_MASK] |=> !o_irq; endproperty
    a_msk: assert property (p_msk) else $error("masked irq seen");
    property p_on;
        cw && i_sfr_wdata[BIT_IRQ_MASK] && i_sfr_wdata[BIT_WRAP_FLAG]
            |=> o_irq;
    endproperty
    a_on: assert property (p_on) else $error("irq missing");
    property p_sw;
        cw && i_sfr_wdata[BIT_WRAP_FLAG] |=> o_cycle_wrap_flag;
    endproperty
    a_sw: assert property (p_sw) else $error("flag write ignored");
    property p_hold; $fell(o_cycle_wrap_flag) |-> $past(clr); endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_set;
        $rose(o_cycle_wrap_flag) |-> $past(i_cnt_tick) || $past(cw);
    endproperty
    a_set: assert property (p_set) else $error("flag set by itself");
    property p_rz; cr |=> o_sfr_rdata[4:2] == 3'h0; endproperty
    a_rz: assert property (p_rz) else $error("unused bits nonzero");
    property p_um;
        i_sfr_rd && i_sfr_addr == 8'h00 |=> o_sfr_rdata == 8'h00;
    endproperty
    a_um: assert property (p_um) else $error("unmapped read nonzero");
    property p_st; !i_sfr_rd |=> $stable(o_sfr_rdata); endproperty
    a_st: assert property (p_st) else $error("read data moved");
    property p_off; i_pwm_en == 6'h00 |=> o_pwm == 6'h00; endproperty
    a_off: assert property (p_off) else $error("pwm out while off");
    c_irq: cover property (o_irq);
    c_wrap: cover property (i_cnt_tick ##1 $rose(o_cycle_wrap_flag));
    c_cmp: cover property (i_sfr_wr && i_sfr_addr == CMP_LOW_BASE);
endmodule : pwm_cycle_config_props
bind pwm_cycle_config pwm_cycle_config_props pwm_cycle_config_props_i (
    .i_sys_clk, .i_arst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
    .i_cnt_tick, .i_pwm_en, .i_wide_pwm_select, .o_sfr_rdata, .o_irq,
    .o_cycle_wrap_flag, .o_pwm);
`default_nettype wire

// [verification/pwm_cycle_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_cycle_config_test
    import pwm_cycle_pkg::*;
;
    // ****************************************
    // Bench signals and design
    // ****************************************
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic i_sfr_rd = 1'b0;
    logic i_cnt_tick = 1'b0;
    logic [NUM_CH-1:0] i_pwm_en = 6'h00;
    logic [NUM_CH-1:0] i_wide_pwm_select = 6'h00;
    wire logic [7:0] o_sfr_rdata;
    wire logic o_irq;
    wire logic o_cycle_wrap_flag;
    wire logic [NUM_CH-1:0] o_pwm;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] v;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    pwm_cycle_config pwm_cycle_config_i (.i_sys_clk, .i_arst_n, .i_sfr_addr,
        .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .i_cnt_tick, .i_pwm_en,
        .i_wide_pwm_select, .o_sfr_rdata, .o_irq, .o_cycle_wrap_flag, .o_pwm);
    initial forever #10 i_sys_clk = ~i_sys_clk;
    // Hang guard, well above the longest wrap waits
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("fails %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Tasks start and end 1 ns after an edge; each strobe gets an idle
    // edge so two calls never touch it twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(posedge i_sys_clk);
        #1 i_sfr_wr = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(posedge i_sys_clk);
        #1 i_sfr_rd = 1'b0;
        @(posedge i_sys_clk);
        #1 chk(o_sfr_rdata, e);
    endtask : rd
    task automatic tk(input int n);
        i_cnt_tick = 1'b1;
        repeat (n) @(posedge i_sys_clk);
        #1 i_cnt_tick = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask : tk
    // Bounded wait for the next cycle wrap, tick held high throughout
    task automatic wf;
        i_cnt_tick = 1'b1;
        for (int j = 0; j < 4096 && o_cycle_wrap_flag !== 1'b1; j++) begin
            @(posedge i_sys_clk);
            #1;
        end
        i_cnt_tick = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask : wf
    initial begin
        repeat (3) @(posedge i_sys_clk);
        #1 i_arst_n = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1 rd(CFG_ADDR, CFG_RESET);
        chk({2'h0, o_pwm}, 8'h00);
        rd(8'h00, 8'h00);
        wr(CFG_ADDR, 8'hff);
        rd(CFG_ADDR, CFG_WMASK);
        chk({7'h00, o_irq}, 8'h01);
        wr(CFG_ADDR, 8'h20);
        chk({7'h00, o_irq}, 8'h00);
        wr(CFG_ADDR, 8'h40);
        rd(CFG_ADDR, 8'h40);
        // Both banks of every channel, normal values must survive
        for (int c = 0; c < NUM_CH; c++) begin
            lo = CMP_LOW_BASE + CMP_STRIDE * 8'(c);
            hi = CMP_HIGH_BASE + CMP_STRIDE * 8'(c);
            v = 8'(c);
            wr(CFG_ADDR, 8'h00);
            wr(lo, 8'h10 + v);
            wr(hi, 8'h20 + v);
            wr(CFG_ADDR, 8'h80);
            wr(lo, 8'h30 + v);
            wr(hi, 8'h40 + v);
            rd(lo, 8'h30 + v);
            rd(hi, 8'h40 + v);
            wr(CFG_ADDR, 8'h00);
            rd(lo, 8'h10 + v);
            rd(hi, 8'h20 + v);
        end
        // Align on a wrap, then count one full cycle per length code
        for (int n = 0; n < 4; n++) begin
            wr(CFG_ADDR, 8'h40 | 8'(n));
            wf();
            wr(CFG_ADDR, 8'h40 | 8'(n));
            tk((1 << (8 + n)) - 1);
            chk({7'h00, o_cycle_wrap_flag}, 8'h00);
            tk(1);
            chk({7'h00, o_cycle_wrap_flag}, 8'h01);
            chk({7'h00, o_irq}, 8'h01);
        end
        i_pwm_en = 6'h3f;
        i_wide_pwm_select = 6'h02;
        wr(CFG_ADDR, 8'h01);
        wf();
        rd(CMP_LOW_BASE, 8'h30);
        rd(CMP_LOW_BASE + CMP_STRIDE, 8'h11);
        wr(CFG_ADDR, 8'h80);
        wr(CMP_LOW_BASE, 8'h55);
        wr(CFG_ADDR, 8'h00);
        wf();
        rd(CMP_LOW_BASE, 8'h30);
        // Counter rests at 0x300; wide ch1 is past its compare 0x0105
        wr(CMP_LOW_BASE + CMP_STRIDE, 8'h05);
        wr(CMP_HIGH_BASE + CMP_STRIDE, 8'h01);
        chk({2'h0, o_pwm}, 8'h3d);
        // 9-bit cycle: only count bits 8:0 meet compare bits 8:0
        wr(CFG_ADDR, 8'h01);
        chk({2'h0, o_pwm}, 8'h28);
        report_and_stop;
    end
endmodule : pwm_cycle_config_test
`default_nettype wire
